// ==== logic/hdic_map.svh ====
// Command codes, field positions, reset values and timing counts
// for the host DMA / interrupt configuration bank.
`ifndef HDIC_MAP_SVH
`define HDIC_MAP_SVH

`define CMD_HW_RD      8'h20
`define CMD_HW_WR      8'hA0
`define CMD_DMA_RD     8'h21
`define CMD_DMA_WR     8'hA1

`define HW_RESET       16'h0028
`define DMA_RESET      16'h0000
`define DMA_MASK       16'h00FF
`define SYNC_INIT      24'hE3_0000

`define HW_OVC_SEL     10
`define HW_ONE_IRQ     9
`define HW_ACK_MODE    8
`define HW_ONE_DMA     7
`define HW_ACK_POL     6
`define HW_REQ_POL     5
`define HW_WIDTH_HI    4
`define HW_WIDTH_LO    3
`define HW_IRQ_POL     2
`define HW_IRQ_TRIG    1
`define HW_IRQ_EN      0
`define BUS_16BIT      2'h1

`define DMA_CNT_EN     7
`define DMA_BURST_HI   6
`define DMA_BURST_LO   5
`define DMA_RUN        4
`define DMA_DIRECT     3
`define DMA_BUF_HI     2
`define DMA_BUF_LO     1
`define DMA_DIR        0

`define CLK_NS         10
`define IRQ_PULSE_NS   100
`define IRQ_PULSE_CYC  ((`IRQ_PULSE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== logic/hdic_pkg.sv ====
// Types shared by the configuration bank.
// Assumes hdic_map.svh holds all numeric constants.
package hdic_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WR   = 3'h2,
      ST_RD   = 3'h4
   } port_state_t;
endpackage

// ==== logic/host_dma_irq_config.sv ====
// Host hardware and DMA configuration registers behind the 16-bit
// command/data microprocessor port, plus the pin routing they steer.
// Assumes interrupt and DMA requests arrive already enabled per source.
// Contract
// - Overcurrent from digital pin or analog detector
// - Interrupts split or shared on primary pin
// - Primary acknowledge qualifies read/write strobes
// - DMA pairs split or shared on primary
// - Primary acknowledge polarity selectable, low default
// - Primary request polarity selectable, high default
// - Bus width code 01 means 16 bits
// - Primary interrupt polarity selectable, low default
// - Primary interrupt level or edge signalling
// - Global enable gates primary interrupt pin
// - Burst code selects 1, 4, 8 cycles
// - Byte counter acts only when enabled
`timescale 1ns/10ps
`include "hdic_map.svh"

module host_dma_irq_config
   import hdic_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_cs_n,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_a0,
   input  wire logic [15:0] i_data,
   input  wire logic        i_oc_digital,
   input  wire logic        i_oc_analog,
   input  wire logic        i_primary_dma_acknowledge,
   input  wire logic        i_secondary_dma_acknowledge_n,
   input  wire logic        i_hc_irq,
   input  wire logic        i_dc_irq,
   input  wire logic        i_hc_dma_req,
   input  wire logic        i_dc_dma_req,
   output logic      [15:0] o_data,
   output logic             o_data_oe,
   output logic             o_overcurrent,
   output logic             o_irq1,
   output logic             o_irq2_n,
   output logic             o_primary_dma_request,
   output logic             o_secondary_dma_request,
   output logic             o_hc_dack,
   output logic             o_dc_dack,
   output logic             o_dma_run,
   output logic             o_count_enable,
   output logic      [3:0]  o_burst_beats,
   output logic      [1:0]  o_buffer_sel,
   output logic             o_direct_addr,
   output logic             o_dma_write,
   output logic             o_bus_width_ok,
   output logic             o_ack_mode_ok
);

   localparam logic [23:0] SYNC_INIT = `SYNC_INIT;
   localparam logic [3:0]  PULSE_CYC = 4'(`IRQ_PULSE_CYC);

   logic [23:0]  pins;
   logic [23:0]  sync1_reg;
   logic [23:0]  sync2_reg;
   port_state_t  state_reg;
   port_state_t  state_next;
   logic [15:0]  wdata_reg;
   logic         wa0_reg;
   logic [7:0]   cmd_reg;
   logic [15:0]  hw_reg;
   logic [15:0]  dma_reg;
   logic         src_prev_reg;
   logic [3:0]   pulse_cnt_reg;
   logic [3:0]   pulse_cnt_next;

   assign pins = {i_cs_n, i_rd_n, i_wr_n, i_a0, i_oc_digital, i_oc_analog,
                  i_primary_dma_acknowledge, i_secondary_dma_acknowledge_n, i_data};

   // Bus, overcurrent and acknowledge pins see two flops before any logic reads them
   genvar g;
   generate
      for (g = 0; g < 24; g = g + 1) begin : g_sync
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               sync1_reg[g] <= SYNC_INIT[g];
               sync2_reg[g] <= SYNC_INIT[g];
            end else begin
               sync1_reg[g] <= pins[g];
               sync2_reg[g] <= sync1_reg[g];
            end
         end
      end
   endgenerate

   wire        cs_s    = sync2_reg[23];
   wire        rd_s    = sync2_reg[22];
   wire        wr_s    = sync2_reg[21];
   wire        a0_s    = sync2_reg[20];
   wire        ocd_s   = sync2_reg[19];
   wire        oca_s   = sync2_reg[18];
   wire        primary_dma_acknowledge_s = sync2_reg[17];
   wire        secondary_dma_acknowledge_s = sync2_reg[16];
   wire [15:0] data_s  = sync2_reg[15:0];

   wire wr_act  = !cs_s && !wr_s;
   wire rd_act  = !cs_s && !rd_s;
   wire wr_done = (state_reg == ST_WR) && !wr_act;

   // Port sequencer: a write takes effect when the strobe releases
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (wr_act) begin
               state_next = ST_WR;
            end else if (rd_act) begin
               state_next = ST_RD;
            end
         end
         ST_WR: begin
            if (!wr_act) begin
               state_next = ST_IDLE;
            end
         end
         ST_RD: begin
            if (!rd_act) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire cmd_wr  = wr_done && wa0_reg;
   wire hw_wr   = wr_done && !wa0_reg && (cmd_reg == `CMD_HW_WR);
   wire dma_wr  = wr_done && !wa0_reg && (cmd_reg == `CMD_DMA_WR);
   wire [15:0] rd_data = (cmd_reg == `CMD_HW_RD)  ? hw_reg :
                         (cmd_reg == `CMD_DMA_RD) ? dma_reg : 16'h0000;

   // Routing and polarity terms
   wire one_irq   = hw_reg[`HW_ONE_IRQ];
   wire one_dma   = hw_reg[`HW_ONE_DMA];
   wire irq1_src  = (i_hc_irq || (one_irq && i_dc_irq))
                    && hw_reg[`HW_IRQ_EN];
   wire irq1_rise = irq1_src && !src_prev_reg;
   wire pulse_on  = (pulse_cnt_reg != 4'h0);
   wire irq1_act  = hw_reg[`HW_IRQ_TRIG] ? pulse_on : irq1_src;
   wire hc_req    = i_hc_dma_req && dma_reg[`DMA_RUN]
                    && dma_reg[`DMA_CNT_EN];
   wire primary_dma_request_act = hc_req || (one_dma && i_dc_dma_req);
   // Acknowledge mode is held at normal; the reserved code is not decoded
   wire strobe    = !rd_s || !wr_s;
   wire primary_dma_acknowledge_act = primary_dma_acknowledge_s ^ !hw_reg[`HW_ACK_POL];
   wire dc_ack    = one_dma ? primary_dma_acknowledge_act : !secondary_dma_acknowledge_s;
   wire [1:0] bcode = dma_reg[`DMA_BURST_HI:`DMA_BURST_LO];
   // Reserved burst code falls back to single cycle
   wire [3:0] beats = (bcode == 2'h1) ? 4'h4 :
                      (bcode == 2'h2) ? 4'h8 : 4'h1;

   assign pulse_cnt_next = irq1_rise ? PULSE_CYC :
                           pulse_on  ? pulse_cnt_reg - 4'h1 : 4'h0;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg     <= ST_IDLE;
         wdata_reg     <= 16'h0000;
         wa0_reg       <= 1'b0;
         cmd_reg       <= 8'h00;
         src_prev_reg  <= 1'b0;
         pulse_cnt_reg <= 4'h0;
      end else begin
         state_reg     <= state_next;
         src_prev_reg  <= irq1_src;
         pulse_cnt_reg <= pulse_cnt_next;
         if (state_reg == ST_WR && wr_act) begin
            wdata_reg <= data_s;
            wa0_reg   <= a0_s;
         end
         if (cmd_wr) begin
            cmd_reg <= wdata_reg[7:0];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hw_reg  <= `HW_RESET;
         dma_reg <= `DMA_RESET;
      end else begin
         if (hw_wr) begin
            hw_reg <= wdata_reg;
         end
         // Run bit stays set until software clears it
         if (dma_wr) begin
            dma_reg <= wdata_reg & `DMA_MASK;
         end
      end
   end

   // All outputs registered
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_data         <= 16'h0000;
         o_data_oe      <= 1'b0;
         o_overcurrent  <= 1'b0;
         o_irq1         <= 1'b1;
         o_irq2_n       <= 1'b1;
         o_primary_dma_request        <= 1'b0;
         o_secondary_dma_request        <= 1'b0;
         o_hc_dack      <= 1'b0;
         o_dc_dack      <= 1'b0;
         o_dma_run      <= 1'b0;
         o_count_enable <= 1'b0;
         o_burst_beats  <= 4'h1;
         o_buffer_sel   <= 2'h0;
         o_direct_addr  <= 1'b0;
         o_dma_write    <= 1'b0;
         o_bus_width_ok <= 1'b1;
         o_ack_mode_ok  <= 1'b1;
      end else begin
         o_data         <= rd_data;
         o_data_oe      <= (state_next == ST_RD);
         o_overcurrent  <= hw_reg[`HW_OVC_SEL] ? oca_s : ocd_s;
         o_irq1         <= irq1_act ^ !hw_reg[`HW_IRQ_POL];
         o_irq2_n       <= !(!one_irq && i_dc_irq);
         o_primary_dma_request        <= primary_dma_request_act ^ !hw_reg[`HW_REQ_POL];
         o_secondary_dma_request        <= !one_dma && i_dc_dma_req;
         o_hc_dack      <= primary_dma_acknowledge_act && strobe;
         o_dc_dack      <= dc_ack && strobe;
         o_dma_run      <= dma_reg[`DMA_RUN];
         o_count_enable <= dma_reg[`DMA_CNT_EN];
         o_burst_beats  <= beats;
         o_buffer_sel   <= dma_reg[`DMA_BUF_HI:`DMA_BUF_LO];
         o_direct_addr  <= dma_reg[`DMA_DIRECT];
         o_dma_write    <= dma_reg[`DMA_DIR];
         o_bus_width_ok <= (hw_reg[`HW_WIDTH_HI:`HW_WIDTH_LO] == `BUS_16BIT);
         o_ack_mode_ok  <= !hw_reg[`HW_ACK_MODE];
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   sequence data_write_s(logic [7:0] c);
      wr_done && !wa0_reg && (cmd_reg == c);
   endsequence

   sequence pulse_hold_s;
      pulse_on [*8];
   endsequence

   AST_OVC_ROUTE: assert property (
      (hw_reg[`HW_OVC_SEL] && $past(hw_reg[`HW_OVC_SEL], 3))
      |-> o_overcurrent == $past(i_oc_analog, 3))
      else $error("overcurrent not taken from analog input");
   AST_IRQ2_IDLE: assert property (
      (one_irq && $past(one_irq)) |-> o_irq2_n)
      else $error("secondary interrupt used in shared mode");
   AST_DACK_QUAL: assert property (
      o_hc_dack |-> $past(!i_rd_n || !i_wr_n, 3))
      else $error("acknowledge without read or write strobe");
   AST_SECONDARY_DMA_REQUEST_IDLE: assert property (
      (one_dma && $past(one_dma)) |-> !o_secondary_dma_request)
      else $error("secondary request used in shared mode");
   AST_DACK_POL: assert property (
      o_hc_dack |-> $past(i_primary_dma_acknowledge, 3) == $past(hw_reg[`HW_ACK_POL]))
      else $error("acknowledge taken at wrong polarity");
   AST_DREQ_POL: assert property (
      !$past(primary_dma_request_act) |-> o_primary_dma_request == !$past(hw_reg[`HW_REQ_POL]))
      else $error("idle request at wrong level");
   AST_WIDTH: assert property (
      hw_wr && (wdata_reg[4:3] != `BUS_16BIT) |=> ##1 !o_bus_width_ok)
      else $error("reserved bus width not flagged");
   AST_IRQ_POL: assert property (
      !$past(irq1_act) |-> o_irq1 == !$past(hw_reg[`HW_IRQ_POL]))
      else $error("idle interrupt at wrong level");
   AST_IRQ_EDGE: assert property (
      irq1_rise |=> pulse_hold_s)
      else $error("edge pulse shorter than expected");
   AST_GLOBAL_EN: assert property (
      !$past(hw_reg[`HW_IRQ_EN]) && !$past(hw_reg[`HW_IRQ_TRIG])
      |-> o_irq1 == !$past(hw_reg[`HW_IRQ_POL]))
      else $error("interrupt asserted while pin disabled");
   AST_BURST: assert property (
      (bcode == 2'h2) |=> o_burst_beats == 4'h8)
      else $error("burst length code 10 not eight cycles");
   AST_HW_WRITE: assert property (
      data_write_s(`CMD_HW_WR) |=> hw_reg == $past(wdata_reg))
      else $error("hardware config write lost");
   AST_DMA_WRITE: assert property (
      data_write_s(`CMD_DMA_WR) |=> dma_reg == ($past(wdata_reg) & `DMA_MASK))
      else $error("dma config write lost");
   AST_COUNT_GATE: assert property (
      !dma_reg[`DMA_CNT_EN] && !one_dma |-> !primary_dma_request_act)
      else $error("request raised with counter disabled");
   AST_RUN_GATE: assert property (
      !$past(dma_reg[`DMA_RUN]) && !$past(one_dma)
      |-> o_primary_dma_request == !$past(hw_reg[`HW_REQ_POL]))
      else $error("request raised with dma stopped");
   AST_DIRECT: assert property (
      dma_reg[`DMA_DIRECT] |=> o_direct_addr)
      else $error("direct addressing not selected");
   AST_DIR: assert property (
      $rose(dma_reg[`DMA_DIR]) |=> o_dma_write)
      else $error("write direction not followed");

endmodule

// ==== bench/host_bus_model.sv ====
// Host processor model driving the command/data pins of the bank.
// Assumes the block samples every pin on the rising edge of i_clk.
`timescale 1ns/10ps
module host_bus_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_data_oe,
   output logic             o_cs_n,
   output logic             o_rd_n,
   output logic             o_wr_n,
   output logic             o_a0,
   output logic [15:0]      o_data
);
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_a0   = 1'b0;
      o_data = 16'h0000;
   end

   // Strobe low 4 cycles, then high 4: above the 2-cycle synchroniser minimum
   task automatic xfer(input logic a0, input logic wr, input logic [15:0] wd,
                       output logic [15:0] rd);
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      o_a0   <= a0;
      o_wr_n <= ~wr;
      o_rd_n <= wr;
      o_data <= wd;
      repeat (4) @(posedge i_clk);
      // Undriven data pins read back inverted, so a missing enable shows
      rd = i_data_oe ? i_rdata : ~i_rdata;
      o_cs_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      // Released bus must not keep showing the last word
      o_data <= ~wd;
      repeat (4) @(posedge i_clk);
   endtask

   task automatic wreg(input logic [7:0] cmd, input logic [15:0] v);
      logic [15:0] d;
      xfer(1'b1, 1'b1, {8'h00, cmd}, d);
      xfer(1'b0, 1'b1, v, d);
   endtask

   task automatic rreg(input logic [7:0] cmd, output logic [15:0] v);
      xfer(1'b1, 1'b1, {8'h00, cmd}, v);
      xfer(1'b0, 1'b0, 16'h0000, v);
   endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the host DMA / interrupt configuration bank.
// Assumes host_bus_model obeys the pin timing of the register port.
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [15:0] hw;
      logic [15:0] dma;
      logic [5:0]  stim;
      logic [16:0] exp;
   } row_t;
   // Last row holds reserved codes on purpose: stored, flagged, single burst
   localparam row_t ROWS [4] = '{
      '{16'h0029, 16'h0090, 6'h2E, 17'h1_2C43},
      '{16'h062D, 16'h00AB, 6'h26, 17'h0_C51F},
      '{16'h0088, 16'h0054, 6'h1B, 17'h0_CA23},
      '{16'h0110, 16'h0066, 6'h05, 17'h0_B070}};

   logic        i_sys_clk = 1'b0;
   logic        i_nrst    = 1'b0;
   logic [5:0]  stim      = 6'h00;
   logic        primary_dma_acknowledge     = 1'b1;
   logic        secondary_dma_acknowledge_n   = 1'b1;
   logic        cs_n, rd_n, wr_n, a0;
   logic [15:0] wdata, o_data, rv;
   logic [16:0] ov;
   logic        o_data_oe, o_overcurrent, o_irq1, o_irq2_n, o_primary_dma_request, o_secondary_dma_request;
   logic        o_hc_dack, o_dc_dack, o_dma_run, o_count_enable, o_direct_addr;
   logic        o_dma_write, o_bus_width_ok, o_ack_mode_ok;
   logic [3:0]  o_burst_beats;
   logic [1:0]  o_buffer_sel;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          cnt;
   int          hc_ack_cnt = 0;
   int          dc_ack_cnt = 0;

   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // Qualified acknowledge cycles, counted between edges
   always @(negedge i_sys_clk) begin
      if (o_hc_dack === 1'b1) hc_ack_cnt++;
      if (o_dc_dack === 1'b1) dc_ack_cnt++;
   end

   assign ov = {o_overcurrent, o_irq1, o_irq2_n, o_primary_dma_request, o_secondary_dma_request, o_dma_run,
                o_count_enable, o_burst_beats, o_buffer_sel, o_direct_addr,
                o_dma_write, o_bus_width_ok, o_ack_mode_ok};

   host_bus_model host_bus_model_i (.i_clk(i_sys_clk), .i_rdata(o_data),
      .i_data_oe(o_data_oe), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_a0(a0),
      .o_data(wdata));

   host_dma_irq_config host_dma_irq_config_i (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_a0(a0), .i_data(wdata), .i_oc_digital(stim[5]),
      .i_oc_analog(stim[4]), .i_primary_dma_acknowledge(primary_dma_acknowledge), .i_secondary_dma_acknowledge_n(secondary_dma_acknowledge_n),
      .i_hc_irq(stim[3]), .i_dc_irq(stim[2]), .i_hc_dma_req(stim[1]),
      .i_dc_dma_req(stim[0]), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_overcurrent(o_overcurrent), .o_irq1(o_irq1), .o_irq2_n(o_irq2_n),
      .o_primary_dma_request(o_primary_dma_request), .o_secondary_dma_request(o_secondary_dma_request), .o_hc_dack(o_hc_dack),
      .o_dc_dack(o_dc_dack), .o_dma_run(o_dma_run),
      .o_count_enable(o_count_enable), .o_burst_beats(o_burst_beats),
      .o_buffer_sel(o_buffer_sel), .o_direct_addr(o_direct_addr),
      .o_dma_write(o_dma_write), .o_bus_width_ok(o_bus_width_ok),
      .o_ack_mode_ok(o_ack_mode_ok));

   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_o(input logic [16:0] got, input logic [16:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: outputs %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge i_sys_clk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(negedge i_sys_clk);
      chk_o(ov, 17'h0_C043);
      host_bus_model_i.rreg(8'h20, rv);
      chk_w(rv, 16'h0028);
      host_bus_model_i.rreg(8'h21, rv);
      chk_w(rv, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         host_bus_model_i.wreg(8'hA0, ROWS[k].hw);
         host_bus_model_i.wreg(8'hA1, {8'h5A, ROWS[k].dma[7:0]});
         @(posedge i_sys_clk);
         stim <= ROWS[k].stim;
         repeat (6) @(posedge i_sys_clk);
         @(negedge i_sys_clk);
         chk_o(ov, ROWS[k].exp);
         host_bus_model_i.rreg(8'h20, rv);
         chk_w(rv, ROWS[k].hw);
         host_bus_model_i.rreg(8'h21, rv);
         chk_w(rv, {8'h00, ROWS[k].dma[7:0]});
      end
      // Edge mode: one 10-cycle pulse per rise, nothing while level holds
      @(posedge i_sys_clk);
      stim <= 6'h00;
      host_bus_model_i.wreg(8'hA0, 16'h002B);
      @(posedge i_sys_clk);
      stim <= 6'h08;
      for (int p = 0; p < 2; p++) begin
         cnt = 0;
         repeat (20) begin
            @(negedge i_sys_clk);
            if (o_irq1 === 1'b0) cnt++;
         end
         chk_w(cnt[15:0], (p == 0) ? 16'h000A : 16'h0000);
      end
      // Unknown command: write dropped, read gives zero
      host_bus_model_i.wreg(8'h33, 16'hFFFF);
      host_bus_model_i.rreg(8'h33, rv);
      chk_w(rv, 16'h0000);
      host_bus_model_i.rreg(8'h20, rv);
      chk_w(rv, 16'h002B);
      // Acknowledges pass only under a strobe; polarity bit flips the sense
      @(posedge i_sys_clk);
      primary_dma_acknowledge   <= 1'b0;
      secondary_dma_acknowledge_n <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
      chk_w({hc_ack_cnt[7:0], dc_ack_cnt[7:0]}, 16'h0000);
      host_bus_model_i.rreg(8'h20, rv);
      chk_w({hc_ack_cnt[7:0], dc_ack_cnt[7:0]}, 16'h0808);
      host_bus_model_i.wreg(8'hA0, 16'h006B);
      host_bus_model_i.rreg(8'h20, rv);
      chk_w(rv, 16'h006B);
      chk_w({hc_ack_cnt[7:0], dc_ack_cnt[7:0]}, 16'h1018);
      // Mid-run reset: registers and pins return to power-up state
      @(posedge i_sys_clk);
      stim    <= 6'h00;
      primary_dma_acknowledge   <= 1'b1;
      secondary_dma_acknowledge_n <= 1'b1;
      i_nrst  <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(negedge i_sys_clk);
      chk_o(ov, 17'h0_C043);
      chk_w({15'h0000, o_data_oe}, 16'h0000);
      host_bus_model_i.rreg(8'h20, rv);
      chk_w(rv, 16'h0028);
      host_bus_model_i.rreg(8'h21, rv);
      chk_w(rv, 16'h0000);
      summarize();
   end
endmodule
